// ==== rtl/sadec_top.sv ====
// System address decoder: region select, boot aliasing and slave steering
// Function
// - Address bits 31:29 pick one of eight regions
// - Little-endian byte lanes within each word
// - One flat 4 GB address space
// - Wait states while slow bridge access pending
// - Flash, external, power/clock bases fixed
// - First bridge window based at 0xC0000000
// - First bridge slots decoded, others reserved
// - Second bridge window based at 0xE0000000
// - Second bridge slots decoded, others reserved
// - Interrupt controller aliased at 0xFFFFF800
// - Boot mode captured at reset exit, held
// - User flash mode: flash at 000 too
// - Factory mode: same map, factory ROM start
// - RAM mode: RAM at 000 too
// - External mode: external memory at 000 too
// - RAM takes byte, halfword, word accesses
// - RAM at 0x20000000, aliased at zero in RAM mode only
// - Software boot-select write remaps from the next edge
// - Pins sampled second edge; enable low gives user
// - Pin code: user, factory, RAM, external
`timescale 1ns/1ps
`include "sadec_consts.svh"

// ---------------------------------------------------------------
// Usage notes
// ---------------------------------------------------------------
// One request outstanding at a time; the master holds it until ready
// Ready pulses one cycle, then one dead cycle before the next take
// Drop valid in the ready cycle, or the same request runs twice
// Requests before the boot mode is sampled are held off, not lost
// Unmapped and reserved areas never select a slave and read zero
// Write data is copied across all lanes; byte enables pick the lane
// RAM beyond its size is a hole rather than a wrap, so a stray
// pointer reads zero instead of quietly corrupting low RAM
// Slow bridge clocks stretch the access through slave ready only;
// the slow flags stay as ports for a later fixed-wait variant
// Software remap accepts any code; the new map holds from next edge
// Clock enable low freezes sequencing, boot sampling and remap alike
// Limitation: no timeout on a slave answer, a dead slave stalls
// the master for good, so every slave must answer in bounded time

module sadec_top
    import sadec_pkg::*;
#(
    parameter int ADDR_W = 32
)
(
    // Clock, reset, enable
    input  wire logic           ref_clk_i,
    input  wire logic           reset_n_i,
    input  wire logic           clk_en_i,
    // Boot strap pins
    input  wire logic           boot_select_enable_i,
    input  wire logic [1:0]     boot_sel_i,
    // Software boot remap from the boot config register
    input  wire logic           boot_cfg_wr_i,
    input  wire logic [1:0]     boot_cfg_i,
    // Bridge clock slower than main clock
    input  wire logic           bridge_a_slow_i,
    input  wire logic           bridge_b_slow_i,
    // Master request side
    input  wire sadec_req_type  req_i,
    output logic                ready_o,
    output logic [31:0]         rdata_o,
    // Slave request side
    output logic                sel_valid_o,
    output sadec_sreq_type      sreq_o,
    output logic [1:0]          boot_mode_o,
    // Slave answer side
    input  wire logic           slave_ready_i,
    input  wire logic [31:0]    slave_rdata_i
);

    // ---------------------------------------------------------------
    // State registers
    // ---------------------------------------------------------------
    sadec_state_all_type st;       // Registered state
    sadec_state_all_type next_st;  // Next state

    // ---------------------------------------------------------------
    // Decode helpers
    // ---------------------------------------------------------------
    logic [2:0]       region;      // Address bits 31:29
    logic [15:0]      ofs;         // Offset within a bridge window
    logic [3:0]       slot;        // Peripheral slot index
    logic             slot_ok;     // Slot is populated
    sadec_target_type tgt;         // Decoded target
    logic [3:0]       be;          // Byte enables
    logic [31:0]      wlane;       // Write data placed on lanes

    // Region and slot decode, combinational from the request
    // From the live request and the held mode so the take edge sees the target;
    // the boot alias reads the registered mode, so a remap written in
    // the same cycle as a take still decodes with the old mapping
    always_comb
    begin
        region  = req_i.addr[31:29];
        ofs     = req_i.addr[15:0];
        slot    = ofs[15:12];
        slot_ok = 1'b0;
        tgt     = SADEC_T_NONE;
        case (region)
            `SADEC_RGN_BOOT:
            begin
                // Boot alias follows the held mode
                case (st.boot_mode)
                    `SADEC_BOOT_USER:    tgt = SADEC_T_FLASH;
                    `SADEC_BOOT_FACTORY: tgt = SADEC_T_FLASH;
                    `SADEC_BOOT_RAM:     tgt = SADEC_T_RAM;
                    `SADEC_BOOT_EXT:     tgt = SADEC_T_EXT;
                    default:             tgt = SADEC_T_FLASH;
                endcase
            end
            `SADEC_RGN_RAM:      tgt = SADEC_T_RAM;
            `SADEC_RGN_FLASH:    tgt = SADEC_T_FLASH;
            `SADEC_RGN_EXT:      tgt = SADEC_T_EXT;
            `SADEC_RGN_PRCU:     tgt = SADEC_T_PRCU;
            `SADEC_RGN_BRIDGE_A:
            begin
                // First bridge: slots 3, 6, 12, 13, 15 unpopulated
                case (slot)
                    4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h7,
                    4'h8, 4'h9, 4'hA, 4'hB, 4'hE: slot_ok = 1'b1;
                    default:                      slot_ok = 1'b0;
                endcase
                tgt = slot_ok ? SADEC_T_BRIDGE_A : SADEC_T_NONE;
            end
            `SADEC_RGN_BRIDGE_B:
            begin
                // Second bridge: 2, 6, 8 empty; top slot only upper half
                case (slot)
                    4'h2, 4'h6, 4'h8: slot_ok = 1'b0;
                    4'hF:             slot_ok = (ofs >= `SADEC_OFS_INTC);
                    default:          slot_ok = 1'b1;
                endcase
                // Top-of-memory alias lands on the same controller
                if (req_i.addr >= `SADEC_INTC_ALIAS)
                begin
                    slot_ok = 1'b1;
                end
                tgt = slot_ok ? SADEC_T_BRIDGE_B : SADEC_T_NONE;
            end
            default:             tgt = SADEC_T_NONE;
        endcase
        // RAM past its size is not backed
        if (tgt == SADEC_T_RAM && req_i.addr[28:16] != 13'h0000)
        begin
            tgt = SADEC_T_NONE;
        end
    end

    // Byte lane enables, little-endian
    // Lane 0 carries the lowest byte address; odd halfword addresses
    // are not trapped, bit 0 is ignored and the pair is aligned down
    always_comb
    begin
        be    = 4'hF;
        wlane = req_i.wdata;
        case (req_i.size)
            2'h0:
            begin
                // Lowest address byte sits in bits 7:0
                be    = 4'h1 << req_i.addr[1:0];
                wlane = {4{req_i.wdata[7:0]}};
            end
            2'h1:
            begin
                be    = req_i.addr[1] ? 4'hC : 4'h3;
                wlane = {2{req_i.wdata[15:0]}};
            end
            default:
            begin
                be    = 4'hF;
                wlane = req_i.wdata;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    // Boot counter runs only until the mode is sampled, then holds;
    // the sequencer walks idle, wait, done for each slave access; holes go idle, done
    always_comb
    begin
        next_st = st;
        // Count edges after reset release, sample on the second
        if (!st.boot_done)
        begin
            next_st.boot_cnt = st.boot_cnt + 2'h1;
            if (st.boot_cnt + 2'h1 == `SADEC_BOOT_EDGE)
            begin
                next_st.boot_done = 1'b1;
                next_st.boot_mode = boot_select_enable_i ? boot_sel_i
                                                         : `SADEC_BOOT_USER;
            end
        end
        else if (boot_cfg_wr_i)
        begin
            // Software remap takes effect next cycle, no reset needed
            next_st.boot_mode = boot_cfg_i;
        end
        next_st.ready = 1'b0;
        case (st.state)
            SADEC_S_IDLE:
            begin
                // Capture the whole request so the slave sees a stable copy
                if (req_i.valid && st.boot_done)
                begin
                    next_st.sreq.target  = tgt;
                    next_st.sreq.write   = req_i.write;
                    next_st.sreq.byte_en = be;
                    next_st.sreq.addr    = req_i.addr;
                    next_st.sreq.wdata   = wlane;
                    next_st.sreq.slot    = slot;
                    if (tgt == SADEC_T_NONE)
                    begin
                        // Reserved: answer at once, data zero
                        next_st.ready = 1'b1;
                        next_st.rdata = 32'h0000_0000;
                        next_st.state = SADEC_S_DONE;
                    end
                    else
                    begin
                        next_st.sel_valid = 1'b1;
                        next_st.state     = SADEC_S_WAIT;
                    end
                end
            end
            SADEC_S_WAIT:
            begin
                // Stall until the slave, slow bridges included, answers
                // Write answers return zero so stale data never leaks out
                if (slave_ready_i)
                begin
                    next_st.sel_valid = 1'b0;
                    next_st.ready     = 1'b1;
                    next_st.rdata     = st.sreq.write ? 32'h0000_0000 : slave_rdata_i;
                    next_st.state     = SADEC_S_DONE;
                end
            end
            SADEC_S_DONE:
            begin
                // One idle cycle lets the master drop its request
                next_st.state = SADEC_S_IDLE;
            end
            default: next_st.state = SADEC_S_IDLE;
        endcase
    end

    // Register the state; enable low freezes everything
    // Reset clears the held boot mode too, so every reset exit
    // samples the strap pins again instead of keeping a stale remap
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st <= '0;
        end
        else if (clk_en_i)
        begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // Outputs, straight from the state register
    // ---------------------------------------------------------------
    // No output has a combinational path from an input, which keeps
    // the master's timing loop to a single register stage
    assign ready_o     = st.ready;
    assign rdata_o     = st.rdata;
    assign sel_valid_o = st.sel_valid;
    assign sreq_o      = st.sreq;
    assign boot_mode_o = st.boot_mode;

    // Slow-bridge flags are informational; the wait comes from slave ready
    logic unused_slow;
    assign unused_slow = bridge_a_slow_i ^ bridge_b_slow_i;

endmodule : sadec_top

// ==== rtl/sadec_consts.svh ====
// Address map constants and timing counts for the system address decoder
`ifndef SADEC_CONSTS_SVH
`define SADEC_CONSTS_SVH

// ---------------------------------------------------------------
// Region codes on address bits 31:29
// ---------------------------------------------------------------
`define SADEC_RGN_BOOT      3'h0
`define SADEC_RGN_RAM       3'h1
`define SADEC_RGN_FLASH     3'h2
`define SADEC_RGN_EXT       3'h3
`define SADEC_RGN_RSVD      3'h4
`define SADEC_RGN_PRCU      3'h5
`define SADEC_RGN_BRIDGE_A  3'h6
`define SADEC_RGN_BRIDGE_B  3'h7

// ---------------------------------------------------------------
// Main block bases
// ---------------------------------------------------------------
`define SADEC_RAM_BASE      32'h2000_0000
`define SADEC_FLASH_BASE    32'h4000_0000
`define SADEC_EXT_BASE      32'h6000_0000
`define SADEC_PRCU_BASE     32'hA000_0000
`define SADEC_BRIDGE_A_BASE 32'hC000_0000
`define SADEC_BRIDGE_B_BASE 32'hE000_0000
`define SADEC_INTC_ALIAS    32'hFFFF_F800
`define SADEC_IRQ_VECTOR    32'h0000_0018
`define SADEC_RAM_BYTES     32'h0001_0000

// ---------------------------------------------------------------
// Peripheral slot offsets
// ---------------------------------------------------------------
`define SADEC_OFS_INTC      16'hF800
`define SADEC_OFS_HALF_SEL  16'h0800

// ---------------------------------------------------------------
// Boot select encodings and reset sampling
// ---------------------------------------------------------------
`define SADEC_BOOT_USER     2'h0
`define SADEC_BOOT_FACTORY  2'h1
`define SADEC_BOOT_RAM      2'h2
`define SADEC_BOOT_EXT      2'h3
`define SADEC_BOOT_EDGE     2'h2

`endif

// ==== rtl/sadec_pkg.sv ====
// Types shared by the system address decoder
package sadec_pkg;

    // ---------------------------------------------------------------
    // Slave targets
    // ---------------------------------------------------------------
    typedef enum logic [3:0]
    {
        SADEC_T_NONE,
        SADEC_T_RAM,
        SADEC_T_FLASH,
        SADEC_T_EXT,
        SADEC_T_PRCU,
        SADEC_T_BRIDGE_A,
        SADEC_T_BRIDGE_B,
        SADEC_T_FACTORY
    } sadec_target_type;

    // Master request
    typedef struct packed
    {
        logic        valid;
        logic        write;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } sadec_req_type;

    // Request steered to one slave
    typedef struct packed
    {
        sadec_target_type target;
        logic             write;
        logic [3:0]       byte_en;
        logic [31:0]      addr;
        logic [31:0]      wdata;
        logic [3:0]       slot;
    } sadec_sreq_type;

    // Access sequencing states
    typedef enum logic [1:0]
    {
        SADEC_S_IDLE,
        SADEC_S_WAIT,
        SADEC_S_DONE
    } sadec_state_type;

    // All decoder state
    typedef struct packed
    {
        sadec_state_type state;
        logic [1:0]      boot_cnt;
        logic            boot_done;
        logic [1:0]      boot_mode;
        logic            sel_valid;
        sadec_sreq_type  sreq;
        logic            ready;
        logic [31:0]     rdata;
    } sadec_state_all_type;

endpackage : sadec_pkg

// ==== tb/sadec_top_checker.sv ====
// Assertion checker for the system address decoder, bound to its top
`timescale 1ns/1ps
module sadec_top_checker
    import sadec_pkg::*;
(
    // Clock and reset
    input wire logic           ref_clk_i,
    input wire logic           reset_n_i,
    // Watched ports
    input wire logic           clk_en_i,
    input wire logic           boot_cfg_wr_i,
    input wire logic [1:0]     boot_cfg_i,
    input wire sadec_req_type  req_i,
    input wire logic           ready_o,
    input wire logic [31:0]    rdata_o,
    input wire logic           sel_valid_o,
    input wire sadec_sreq_type sreq_o,
    input wire logic [1:0]     boot_mode_o,
    input wire logic           slave_ready_i
);
    // Expected slave for a region; block zero follows the boot mapping
    function automatic sadec_target_type tgt_f(input logic [2:0] rg, input logic [1:0] md);
        case (rg)
            3'h0: return md == 2'h2 ? SADEC_T_RAM : md == 2'h3 ? SADEC_T_EXT : SADEC_T_FLASH;
            3'h1: return SADEC_T_RAM;
            3'h2: return SADEC_T_FLASH;
            3'h3: return SADEC_T_EXT;
            3'h5: return SADEC_T_PRCU;
            3'h6: return SADEC_T_BRIDGE_A;
            3'h7: return SADEC_T_BRIDGE_B;
            default: return SADEC_T_NONE;
        endcase
    endfunction : tgt_f

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    AST_TARGET: assert property ($rose(sel_valid_o) |->
        sreq_o.target == tgt_f(req_i.addr[31:29], boot_mode_o)) else $error("bad target");
    AST_LANES: assert property ($rose(sel_valid_o) |-> sreq_o.byte_en ==
        (req_i.size == 2'h0 ? 4'h1 << req_i.addr[1:0] : req_i.size == 2'h1 ?
        (req_i.addr[1] ? 4'hC : 4'h3) : 4'hF)) else $error("bad byte lanes");
    AST_SLOT: assert property ($rose(sel_valid_o) && req_i.addr[31:30] == 2'h3 |->
        sreq_o.slot == req_i.addr[15:12]) else $error("bad slot");
    AST_RSVD_QUIET: assert property (clk_en_i && req_i.valid && !sel_valid_o && !ready_o
        && req_i.addr[31:29] == 3'h4 |=> !sel_valid_o) else $error("reserved selected");
    AST_RSVD_ZERO: assert property (ready_o && !$past(sel_valid_o) |->
        rdata_o == 32'h0000_0000) else $error("reserved data not zero");
    AST_WAIT: assert property (clk_en_i && sel_valid_o && !slave_ready_i |=>
        sel_valid_o && !ready_o) else $error("wait state lost");
    AST_DONE: assert property (clk_en_i && sel_valid_o && slave_ready_i |=>
        ready_o && !sel_valid_o) else $error("answer not passed");
    AST_REMAP: assert property (clk_en_i && boot_cfg_wr_i |=>
        boot_mode_o == $past(boot_cfg_i)) else $error("remap not applied");
    AST_HOLD: assert property (ready_o && !$past(boot_cfg_wr_i) |->
        $stable(boot_mode_o)) else $error("boot mode moved");
endmodule : sadec_top_checker

bind sadec_top sadec_top_checker u_chk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i), .boot_cfg_wr_i(boot_cfg_wr_i), .boot_cfg_i(boot_cfg_i),
    .req_i(req_i), .ready_o(ready_o), .rdata_o(rdata_o), .sel_valid_o(sel_valid_o),
    .sreq_o(sreq_o), .boot_mode_o(boot_mode_o), .slave_ready_i(slave_ready_i));

// ==== tb/sadec_slave_model.sv ====
// Slave side responder with a settable answer delay
`timescale 1ns/1ps
module sadec_slave_model
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    // Select and delay
    input  wire logic        sel_valid_i,
    input  wire logic [3:0]  delay_i,
    // Answer
    output logic             slave_ready_o,
    output logic [31:0]      slave_rdata_o
);
    logic [3:0] wait_cnt;  // Cycles spent on this select
    // Answer after the delay; data toggles outside the answer cycle
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wait_cnt      <= 4'h0;
            slave_ready_o <= 1'b0;
            slave_rdata_o <= 32'h0000_0000;
        end
        else if (sel_valid_i && !slave_ready_o && wait_cnt == delay_i)
        begin
            slave_ready_o <= 1'b1;
            slave_rdata_o <= 32'h1234_5678;
        end
        else
        begin
            wait_cnt      <= (sel_valid_i && !slave_ready_o) ? wait_cnt + 4'h1 : 4'h0;
            slave_ready_o <= 1'b0;
            slave_rdata_o <= ~slave_rdata_o;  // Never a stale copy
        end
    end
endmodule : sadec_slave_model

// ==== tb/system_address_decoder_tb_top.sv ====
// Self-checking bench for the system address decoder
`timescale 1ns/1ps
module system_address_decoder_tb_top
    import sadec_pkg::*;
;
    logic ref_clk_i, reset_n_i, clk_en, boot_en, cfg_wr, slow_a, ready, selv, sl_rdy;
    logic [1:0]     boot_sel, cfg, bmode;
    logic [3:0]     dly;       // Slave answer delay
    logic [31:0]    rdata, sl_rdata;
    sadec_req_type  req;
    sadec_sreq_type sreq;
    int             n_mismatch = 0;
    int             checked = 0;

    sadec_top dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
        .boot_select_enable_i(boot_en), .boot_sel_i(boot_sel), .boot_cfg_wr_i(cfg_wr),
        .boot_cfg_i(cfg), .bridge_a_slow_i(slow_a), .bridge_b_slow_i(1'b0), .req_i(req),
        .ready_o(ready), .rdata_o(rdata), .sel_valid_o(selv), .sreq_o(sreq),
        .boot_mode_o(bmode), .slave_ready_i(sl_rdy), .slave_rdata_i(sl_rdata));
    sadec_slave_model u_slv (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .sel_valid_i(selv), .delay_i(dly), .slave_ready_o(sl_rdy), .slave_rdata_o(sl_rdata));

    initial
    begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    task automatic test_done;
        if (n_mismatch == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    // Reset with straps, then the mapping picked at the second edge
    task automatic boot(input logic en, input logic [1:0] s, input logic [1:0] em);
        @(posedge ref_clk_i);
        reset_n_i <= 1'b0;
        boot_en   <= en;
        boot_sel  <= s;
        repeat (5) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        @(posedge ref_clk_i);
        #1 cmp("boot_early", 32'h0, 32'(bmode));
        @(posedge ref_clk_i);
        boot_sel <= ~s;
        #1 cmp("boot_mode", 32'(em), 32'(bmode));
        @(posedge ref_clk_i);
        #1 cmp("boot_held", 32'(em), 32'(bmode));
    endtask : boot

    // One access; valid drops in the cycle that carries ready
    task automatic acc(input logic [31:0] a, input logic [1:0] sz, input logic w,
                       input logic [3:0] tg, input logic [3:0] el, input logic [31:0] ed);
        int          i;
        logic        seen;
        logic [31:0] ew;
        seen = 1'b0;
        // Write data as it must stand on the lanes for this size
        ew   = (sz == 2'h0) ? 32'hA1A1_A1A1 : (sz == 2'h1) ? 32'h32A1_32A1 : 32'h7654_32A1;
        @(posedge ref_clk_i);
        req <= '{1'b1, w, sz, a, 32'h7654_32A1};
        for (i = 0; i < 40; i++)
        begin
            @(posedge ref_clk_i);
            if (selv && !seen)
            begin
                seen = 1'b1;
                cmp("target", 32'(tg), 32'(sreq.target));
                cmp("lanes", 32'(el), 32'(sreq.byte_en));
                cmp("sel_addr", a, sreq.addr);
                cmp("sel_write", 32'(w), 32'(sreq.write));
                cmp("sel_wdata", ew, sreq.wdata);
                cmp("sel_slot", 32'(a[15:12]), 32'(sreq.slot));
            end
            if (tg == SADEC_T_NONE || (selv && sl_rdy))
                break;
        end
        if (i == 40)
        begin
            n_mismatch++;
            test_done();
        end
        req.valid <= 1'b0;
        #1 cmp("ready", 32'h1, 32'(ready));
        cmp("rdata", ed, rdata);
        cmp("sel_after", 32'h0, 32'(selv));
        @(posedge ref_clk_i);
    endtask : acc

    // Every strap setting and where block zero lands
    task automatic t_boot;
        logic [3:0] tg[5] = '{SADEC_T_FLASH, SADEC_T_FLASH, SADEC_T_FLASH, SADEC_T_RAM,
                              SADEC_T_EXT};
        for (int k = 0; k < 5; k++)
        begin
            boot(k != 0, k == 0 ? 2'h3 : 2'(k - 1), k == 0 ? 2'h0 : 2'(k - 1));
            acc(32'h0000_0100, 2'h2, 1'b0, tg[k], 4'hF, 32'h1234_5678);
        end
    endtask : t_boot

    // Fixed bases, bridge slots, alias and reserved holes
    task automatic t_map;
        logic [31:0] ad[15] = '{32'h2000_0000, 32'h4000_0000, 32'h6000_0000, 32'hA000_0000,
            32'hC000_8800, 32'hC000_E800, 32'hE000_7000, 32'hE000_F800, 32'hFFFF_F800,
            32'h8000_0000, 32'hC000_3000, 32'hC000_F000, 32'hE000_2000, 32'hE000_6000,
            32'h2001_0000};
        logic [3:0] tg[9] = '{SADEC_T_RAM, SADEC_T_FLASH, SADEC_T_EXT, SADEC_T_PRCU,
            SADEC_T_BRIDGE_A, SADEC_T_BRIDGE_A, SADEC_T_BRIDGE_B, SADEC_T_BRIDGE_B,
            SADEC_T_BRIDGE_B};
        for (int k = 0; k < 15; k++)
            if (k < 9)
                acc(ad[k], 2'h2, 1'b0, tg[k], 4'hF, 32'h1234_5678);
            else
                acc(ad[k], 2'h2, 1'b0, SADEC_T_NONE, 4'h0, 32'h0000_0000);
    endtask : t_map

    // Byte and halfword lanes, then a slow bridge read
    task automatic t_lanes;
        for (int k = 0; k < 4; k++)
            acc(32'h2000_0000 + k, 2'h0, 1'b1, SADEC_T_RAM, 4'h1 << k, 32'h0);
        acc(32'h2000_0002, 2'h1, 1'b1, SADEC_T_RAM, 4'hC, 32'h0000_0000);
        dly    <= 4'h5;
        slow_a <= 1'b1;
        acc(32'hC000_1000, 2'h2, 1'b0, SADEC_T_BRIDGE_A, 4'hF, 32'h1234_5678);
        dly    <= 4'h0;
        slow_a <= 1'b0;
    endtask : t_lanes

    // Software remap to RAM at block zero without reset
    task automatic t_remap;
        cfg_wr <= 1'b1;
        cfg    <= 2'h2;
        @(posedge ref_clk_i);
        cfg_wr <= 1'b0;
        #1 cmp("remap_mode", 32'h2, 32'(bmode));
        acc(32'h0000_0018, 2'h2, 1'b0, SADEC_T_RAM, 4'hF, 32'h1234_5678);
    endtask : t_remap

    // Enable low freezes the mapping even against a software write
    task automatic t_freeze;
        clk_en <= 1'b0;
        cfg_wr <= 1'b1;
        cfg    <= 2'h3;
        repeat (2) @(posedge ref_clk_i);
        #1 cmp("frozen_mode", 32'h2, 32'(bmode));
        @(posedge ref_clk_i);
        clk_en <= 1'b1;
        cfg_wr <= 1'b0;
        @(posedge ref_clk_i);
        #1 cmp("thawed_mode", 32'h2, 32'(bmode));
    endtask : t_freeze

    initial
    begin
        reset_n_i = 1'b0;
        clk_en    = 1'b1;
        boot_en   = 1'b0;
        boot_sel  = 2'h0;
        cfg_wr    = 1'b0;
        cfg       = 2'h0;
        slow_a    = 1'b0;
        dly       = 4'h0;
        req       = '0;
        t_boot();
        boot(1'b0, 2'h0, 2'h0);
        t_map();
        t_lanes();
        t_remap();
        t_freeze();
        test_done();
    end
endmodule : system_address_decoder_tb_top
